// [inc/rf_ctrl_defines.svh]
// addresses, reset values, write masks and field positions of the receiver control bank
`ifndef RF_CTRL_DEFINES_SVH
`define RF_CTRL_DEFINES_SVH
// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define A_SOFT_RESET    8'h00
`define A_POWER_EN      8'h01
`define A_INT_DIV       8'h02
`define A_FRACTION      8'h03
`define A_MODULUS       8'h04
`define A_PUMP          8'h20
`define A_REFERENCE     8'h21
`define A_OSC_OUT       8'h22
`define A_INPUT_SW      8'h23
`define A_TRANSFORMER   8'h30
`define A_MIXER         8'h31
`define A_DETECTOR      8'h40
`define A_DITHER        8'h42
`define A_DITHER_SEED   8'h43
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define R_POWER_EN      16'h8b7f
`define R_INT_DIV       16'h0058
`define R_FRACTION      16'h0250
`define R_MODULUS       16'h0600
`define R_PUMP          16'h0c26
`define R_REFERENCE     16'h0003
`define R_OSC_OUT       16'h000a
`define R_INPUT_SW      16'h0000
`define R_TRANSFORMER   16'h0000
`define R_MIXER         16'h08ef
`define R_DETECTOR      16'h0010
`define R_DITHER        16'h000e
`define R_DITHER_SEED   16'h0001
// ----------------------------------------------------------------
// writable bits, reserved bits are zero here
// ----------------------------------------------------------------
`define M_POWER_EN      16'h8bbf
`define M_INT_DIV       16'h0fff
`define M_FRACTION      16'h07ff
`define M_MODULUS       16'h07ff
`define M_PUMP          16'h3c3f
`define M_REFERENCE     16'h007f
`define M_OSC_OUT       16'h019f
`define M_INPUT_SW      16'h0fff
`define M_TRANSFORMER   16'h00ee
`define M_MIXER         16'h0fef
`define M_DETECTOR      16'h007f
`define M_DITHER        16'h000f
`define M_DITHER_SEED   16'hffff
// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define B_SOFT_RESET    0
`define B_AMP_ON        11
`define B_PATH_ON       8
`define B_DRIVER_ON     7
`define B_REFBUF_ON     5
`define B_CORES_ON      4
`define B_DIVIDER_ON    3
`define B_PUMP_ON       2
`define B_DIV_MODE      11
`define F_DIV_VALUE     10:0
`define F_OSC_SRC       2:0
`define F_ATTEN         4:0
`define C_EXT_OSC       3'h3
`define C_ATTEN_MAX     5'h18
`define C_ATTEN_BASE    6'h06
`define C_NO_REG        4'hf
`endif

// [inc/rf_ctrl_pkg.sv]
// shared types of the receiver control bank
package rf_ctrl_pkg;
    typedef logic [15:0] word_t;   // one control word
    typedef logic [7:0]  addr_t;   // register address
    typedef logic [3:0]  index_t;  // storage slot
endpackage

// [inc/power_ctrl_if.sv]
// control words out of the bank and gated block enables back
`timescale 1ns/100ps
interface power_ctrl_if;
    import rf_ctrl_pkg::*;
    word_t power_word;   // block enable register
    word_t osc_word;     // oscillator output register
    logic  ext_osc_mode; // external oscillator routed
    logic  pump_on;      // gated charge pump enable
    logic  divider_on;   // gated divider enable
    logic  refbuf_on;    // gated reference buffer enable
    logic  driver_on;    // gated oscillator driver enable
    logic  cores_on;     // gated oscillator core enable
    logic  amp_on;       // intermediate amplifier enable
    logic  loop_on;      // synthesizer loop active
    modport bank (output power_word, osc_word,
                  input  ext_osc_mode, pump_on, divider_on, refbuf_on,
                  input  driver_on, cores_on, amp_on, loop_on);
    modport gate (input  power_word, osc_word,
                  output ext_osc_mode, pump_on, divider_on, refbuf_on,
                  output driver_on, cores_on, amp_on, loop_on);
endinterface

// [rtl/cfg_word.sv]
// one control word with reset value and write mask
`timescale 1ns/100ps
module cfg_word
    import rf_ctrl_pkg::*;
#(
    parameter word_t RST_VAL = 16'h0000,  // value after any reset
    parameter word_t WMASK   = 16'hffff   // bits that software may change
)(
    // clock and resets
    input  wire logic  i_clk,
    input  wire logic  i_sys_rst,
    input  wire logic  i_soft_clr,
    // write strobe
    input  wire logic  i_we,
    input  wire word_t i_wdata,
    // stored word
    output word_t      o_q
);
    word_t word_q;  // stored value

    // reset and soft reset restore; reserved bits keep their reset value
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || i_soft_clr)
            word_q <= RST_VAL;
        else if (i_we)
            word_q <= (word_q & ~WMASK) | (i_wdata & WMASK);
    end

    assign o_q = word_q;
endmodule

// [rtl/power_gate.sv]
// turns enable bits into block power controls, honouring the oscillator source
`timescale 1ns/100ps
`include "rf_ctrl_defines.svh"
module power_gate
    import rf_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // words in, gated enables out
    power_ctrl_if.gate ctl
);
    logic [2:0] src;      // oscillator source code
    logic       ext_sel;  // external oscillator chosen
    logic       core_sel; // an internal core chosen

    assign src      = ctl.osc_word[`F_OSC_SRC];
    assign ext_sel  = (src == `C_EXT_OSC);
    assign core_sel = (src < `C_EXT_OSC);

    // registered enables; synthesizer parts held off when external source is chosen
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ctl.ext_osc_mode <= 1'b0;
            ctl.pump_on      <= 1'b0;
            ctl.divider_on   <= 1'b0;
            ctl.refbuf_on    <= 1'b0;
            ctl.driver_on    <= 1'b0;
            ctl.cores_on     <= 1'b0;
            ctl.amp_on       <= 1'b0;
            ctl.loop_on      <= 1'b0;
        end
        else
        begin
            ctl.ext_osc_mode <= ext_sel;
            ctl.pump_on      <= ctl.power_word[`B_PUMP_ON] & ~ext_sel;
            ctl.divider_on   <= ctl.power_word[`B_DIVIDER_ON] & ~ext_sel;
            ctl.refbuf_on    <= ctl.power_word[`B_REFBUF_ON] & ~ext_sel;
            ctl.driver_on    <= ctl.power_word[`B_DRIVER_ON] & ~ext_sel;
            ctl.cores_on     <= ctl.power_word[`B_CORES_ON] & core_sel;
            ctl.amp_on       <= ctl.power_word[`B_AMP_ON];
            ctl.loop_on      <= ctl.power_word[`B_PUMP_ON] & ctl.power_word[`B_DIVIDER_ON]
                                & ctl.power_word[`B_REFBUF_ON] & core_sel;
        end
    end
endmodule

// [rtl/rf_ctrl_regs.sv]
// control register bank of the receiver mixer and synthesizer
// Notes on behaviour
// - each analog block has its own enable bit
// - external oscillator needs source select 011
// - synthesizer loop and oscillator off then
// - amplifier off when enable bit 11 clear
// - soft reset word is write only
// - upper enable byte layout, reset 0x8b7f
// - lower enable byte layout fixed
// - divider mode and integer value, reset 0x0058
// - fraction value eleven bits, reset 0x0250
// - modulus value eleven bits, reset 0x0600
// - pump current and current_a fields, reset 0x0c26
// - reference path fields, reset 0x0003
// - drive level, divide, source; reset 0x000a
// - switch source, port, attenuators; reset 0x0000
// - transformer capacitance fields, reset zero
// - mixer bias and trims, reset 0x08ef
// - detector delay, pump, edge; reset 0x0010
// - dither enable, magnitude, value; reset 0x000e
// - sixteen bit dither seed, reset 0x0001
// - mode bit: zero fractional, one integer
// - gain attenuation 3 dB plus half steps
`timescale 1ns/100ps
`include "rf_ctrl_defines.svh"
module rf_ctrl_regs
    import rf_ctrl_pkg::*;
#(
    parameter int NREG = 13  // stored control words
)(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // register access from the serial port
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    input  wire addr_t       i_addr,
    input  wire word_t       i_wdata,
    output word_t            o_rdata,
    output logic             o_rd_valid,
    // block power controls
    output logic             o_ext_osc_mode,
    output logic             o_pump_on,
    output logic             o_divider_on,
    output logic             o_refbuf_on,
    output logic             o_osc_driver_on,
    output logic             o_oscillator_cores_on,
    output logic             o_intermediate_amp_on,
    output logic             o_synth_loop_on,
    output word_t            o_power_word,
    // synthesizer settings
    output logic             o_integer_mode,
    output logic [10:0]      o_integer_value,
    output logic [10:0]      o_fraction_value,
    output logic [10:0]      o_modulus_value,
    // analog configuration words
    output word_t            o_pump_cfg,
    output word_t            o_reference_cfg,
    output word_t            o_osc_out_cfg,
    output word_t            o_input_switch_cfg,
    output word_t            o_transformer_cfg,
    output word_t            o_mixer_cfg,
    output word_t            o_detector_cfg,
    output word_t            o_dither_cfg,
    output word_t            o_dither_seed,
    // gain attenuation in half dB
    output logic [5:0]       o_atten_half_db
);
    // ----------------------------------------------------------------
    // register tables
    // ----------------------------------------------------------------
    // address, reset value and write mask per slot
    localparam addr_t ADDR_TAB [NREG] = '{`A_POWER_EN, `A_INT_DIV, `A_FRACTION,
        `A_MODULUS, `A_PUMP, `A_REFERENCE, `A_OSC_OUT, `A_INPUT_SW,
        `A_TRANSFORMER, `A_MIXER, `A_DETECTOR, `A_DITHER, `A_DITHER_SEED};
    localparam word_t RST_TAB [NREG] = '{`R_POWER_EN, `R_INT_DIV, `R_FRACTION,
        `R_MODULUS, `R_PUMP, `R_REFERENCE, `R_OSC_OUT, `R_INPUT_SW,
        `R_TRANSFORMER, `R_MIXER, `R_DETECTOR, `R_DITHER, `R_DITHER_SEED};
    localparam word_t MASK_TAB [NREG] = '{`M_POWER_EN, `M_INT_DIV, `M_FRACTION,
        `M_MODULUS, `M_PUMP, `M_REFERENCE, `M_OSC_OUT, `M_INPUT_SW,
        `M_TRANSFORMER, `M_MIXER, `M_DETECTOR, `M_DITHER, `M_DITHER_SEED};

    // slot numbers of words read by name
    localparam int I_EN  = 0;
    localparam int I_INT = 1;
    localparam int I_FR  = 2;
    localparam int I_MOD = 3;
    localparam int I_OSC = 6;
    localparam int I_SW  = 7;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // maps an address to its slot, or the no-register code
    function automatic index_t slot_of(input addr_t a);
        index_t s;
        s = `C_NO_REG;
        for (int k = 0; k < NREG; k++)
        begin
            if (ADDR_TAB[k] == a)
                s = index_t'(k);
        end
        return s;
    endfunction

    index_t wr_slot;   // slot hit by a write
    index_t rd_slot;   // slot hit by a read
    logic   soft_hit;  // write sets the soft reset bit
    logic   soft_q;    // soft reset pulse, one cycle

    // same decode for write and read
    assign wr_slot  = slot_of(i_addr);
    assign rd_slot  = slot_of(i_addr);
    assign soft_hit = i_wr_en && (i_addr == `A_SOFT_RESET) && i_wdata[`B_SOFT_RESET];

    // ----------------------------------------------------------------
    // soft reset
    // ----------------------------------------------------------------
    // pulse from a write of one; nothing is stored, so it clears itself
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            soft_q <= 1'b0;
        else
            soft_q <= soft_hit;
    end

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    word_t reg_q [NREG];  // stored words

    // one word per slot; the soft pulse restores every slot
    generate
        for (genvar g = 0; g < NREG; g++)
        begin : g_word
            cfg_word #(
                .RST_VAL (RST_TAB[g]),
                .WMASK   (MASK_TAB[g])
            ) u_word (
                .i_clk      (i_clk),
                .i_sys_rst  (i_sys_rst),
                .i_soft_clr (soft_q),
                .i_we       (i_wr_en && (wr_slot == index_t'(g))),
                .i_wdata    (i_wdata),
                .o_q        (reg_q[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // one cycle read; soft reset word and unmapped addresses read zero
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_rdata    <= 16'h0000;
            o_rd_valid <= 1'b0;
        end
        else
        begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en && rd_slot != `C_NO_REG)
                o_rdata <= reg_q[rd_slot];
            else
                o_rdata <= 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // power gating
    // ----------------------------------------------------------------
    power_ctrl_if ctl ();  // words to the gate, enables back

    assign ctl.power_word = reg_q[I_EN];
    assign ctl.osc_word   = reg_q[I_OSC];

    power_gate u_gate (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .ctl       (ctl)
    );

    // gated enables to the ports
    assign o_ext_osc_mode        = ctl.ext_osc_mode;
    assign o_pump_on             = ctl.pump_on;
    assign o_divider_on          = ctl.divider_on;
    assign o_refbuf_on           = ctl.refbuf_on;
    assign o_osc_driver_on       = ctl.driver_on;
    assign o_oscillator_cores_on = ctl.cores_on;
    assign o_intermediate_amp_on = ctl.amp_on;
    assign o_synth_loop_on       = ctl.loop_on;

    // ----------------------------------------------------------------
    // configuration outputs
    // ----------------------------------------------------------------
    // fields straight from the stored flops
    assign o_power_word       = reg_q[I_EN];
    assign o_integer_mode     = reg_q[I_INT][`B_DIV_MODE];
    assign o_integer_value    = reg_q[I_INT][`F_DIV_VALUE];
    assign o_fraction_value   = reg_q[I_FR][`F_DIV_VALUE];
    assign o_modulus_value    = reg_q[I_MOD][`F_DIV_VALUE];
    assign o_pump_cfg         = reg_q[4];
    assign o_reference_cfg    = reg_q[5];
    assign o_osc_out_cfg      = reg_q[I_OSC];
    assign o_input_switch_cfg = reg_q[I_SW];
    assign o_transformer_cfg  = reg_q[8];
    assign o_mixer_cfg        = reg_q[9];
    assign o_detector_cfg     = reg_q[10];
    assign o_dither_cfg       = reg_q[11];
    assign o_dither_seed      = reg_q[12];

    // ----------------------------------------------------------------
    // gain attenuation
    // ----------------------------------------------------------------
    logic [4:0] atten_code;  // attenuation code, clipped to top step

    assign atten_code = (reg_q[I_SW][`F_ATTEN] > `C_ATTEN_MAX) ? `C_ATTEN_MAX
                                                             : reg_q[I_SW][`F_ATTEN];

    // half dB figure: 3 dB at code zero, half dB per code
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_atten_half_db <= `C_ATTEN_BASE;
        else
            o_atten_half_db <= `C_ATTEN_BASE + {1'b0, atten_code};
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // reset restores the words
    a_reset_values: assert property (disable iff (1'b0) i_sys_rst |=>
        (reg_q[I_EN] == `R_POWER_EN) && (reg_q[I_INT] == `R_INT_DIV))
        else $error("control words not at reset value");

    // enable word takes a write
    a_enable_write: assert property (i_wr_en && i_addr == `A_POWER_EN && !soft_q |=>
        reg_q[I_EN] == (($past(i_wdata) & `M_POWER_EN) | (`R_POWER_EN & ~`M_POWER_EN)))
        else $error("enable word did not take the write");

    // soft pulse restores words
    a_soft_restore: assert property (soft_q |=>
        (reg_q[I_EN] == `R_POWER_EN) && (reg_q[I_OSC] == `R_OSC_OUT)
        && (reg_q[12] == `R_DITHER_SEED) && (reg_q[I_MOD] == `R_MODULUS))
        else $error("soft reset did not restore words");

    // soft pulse lasts one cycle
    a_soft_clears: assert property (soft_q && !soft_hit |=> !soft_q)
        else $error("soft reset bit stuck");

    // soft reset word reads zero
    a_write_only: assert property (i_rd_en && i_addr == `A_SOFT_RESET |=>
        o_rd_valid && o_rdata == 16'h0000)
        else $error("soft reset word read back nonzero");

    // reserved divider bits stay zero
    a_reserved_zero: assert property ((reg_q[I_INT] & ~`M_INT_DIV) == 16'h0000
        && (reg_q[I_FR] & ~`M_FRACTION) == 16'h0000)
        else $error("reserved bits took a write");

    // external source parks the loop
    a_ext_osc_off: assert property (reg_q[I_OSC][`F_OSC_SRC] == `C_EXT_OSC |=>
        o_ext_osc_mode && !o_pump_on && !o_synth_loop_on && !o_oscillator_cores_on)
        else $error("synthesizer active with external oscillator");

    // amplifier follows a clear bit
    a_amp_off: assert property (!reg_q[I_EN][`B_AMP_ON] ##1 !reg_q[I_EN][`B_AMP_ON]
        |-> !o_intermediate_amp_on)
        else $error("amplifier on while its bit is clear");

    // attenuation figure per code
    a_atten_map: assert property (##1 reg_q[I_SW][`F_ATTEN] <= `C_ATTEN_MAX |=>
        o_atten_half_db == `C_ATTEN_BASE + $past(reg_q[I_SW][`F_ATTEN]))
        else $error("attenuation figure mismatched");

    // divider mode taken from write
    a_div_mode: assert property (i_wr_en && i_addr == `A_INT_DIV && !soft_q |=>
        o_integer_mode == $past(i_wdata[`B_DIV_MODE]))
        else $error("divider mode bit not applied");

    // external setup word parks parts
    a_ext_setup: assert property (reg_q[I_EN] == 16'h8b53 && o_ext_osc_mode |->
        !o_divider_on && !o_refbuf_on && !o_osc_driver_on)
        else $error("external mode left loop parts on");

    // read returns the stored word
    a_read_data: assert property (i_rd_en && rd_slot != `C_NO_REG |=>
        o_rd_valid && o_rdata == $past(reg_q[rd_slot]))
        else $error("read returned wrong word");

    // no request, no answer
    a_read_idle: assert property (!i_rd_en |=>
        !o_rd_valid && o_rdata == 16'h0000)
        else $error("read answer without request");

    // parked core codes keep cores off
    a_cores_parked: assert property (reg_q[I_OSC][`F_OSC_SRC] > `C_EXT_OSC |=>
        !o_oscillator_cores_on && !o_synth_loop_on)
        else $error("oscillator core on while parked");

    // pump and divider follow bits
    a_enable_follow: assert property (reg_q[I_OSC][`F_OSC_SRC] < `C_EXT_OSC |=>
        o_pump_on == $past(reg_q[I_EN][`B_PUMP_ON]) && o_divider_on == $past(reg_q[I_EN][`B_DIVIDER_ON]))
        else $error("block enable did not follow its bit");

    // amplifier on with its bit
    a_amp_on: assert property (reg_q[I_EN][`B_AMP_ON] |=>
        o_intermediate_amp_on)
        else $error("amplifier off while its bit is set");

    // soft pulse restores other words
    a_soft_others: assert property (soft_q |=>
        (reg_q[4] == `R_PUMP) && (reg_q[9] == `R_MIXER) && (reg_q[I_SW] == `R_INPUT_SW))
        else $error("soft reset missed a word");

    // reserved enable bit keeps reset
    a_reserved_keep: assert property ((reg_q[I_EN] & ~`M_POWER_EN) == (`R_POWER_EN & ~`M_POWER_EN)
        && (reg_q[I_OSC] & ~`M_OSC_OUT) == 16'h0000)
        else $error("reserved enable bit changed");

    // driver and buffer follow bits
    a_driver_follow: assert property (reg_q[I_OSC][`F_OSC_SRC] != `C_EXT_OSC |=>
        o_osc_driver_on == $past(reg_q[I_EN][`B_DRIVER_ON]) && o_refbuf_on == $past(reg_q[I_EN][`B_REFBUF_ON]))
        else $error("driver or buffer enable did not follow");

    // scenarios to be reached
    c_atten_clip: cover property (reg_q[I_SW][`F_ATTEN] > `C_ATTEN_MAX);
    c_soft_reset: cover property (soft_q ##1 reg_q[I_EN] == `R_POWER_EN);
    c_ext_mode:   cover property (o_ext_osc_mode && reg_q[I_EN] == 16'h8b53);
    c_amp_down:   cover property ($fell(o_intermediate_amp_on));
    c_read_back:  cover property (i_rd_en && i_addr == `A_DITHER_SEED ##1 o_rd_valid);
endmodule

// [test/reg_host.sv]
// host model that writes and reads control words over the register port
`timescale 1ns/100ps
module reg_host
    import rf_ctrl_pkg::*;
(
    // clock
    input  wire logic  i_clk,
    // answer from the bank
    input  wire word_t i_rdata,
    input  wire logic  i_rd_valid,
    // request to the bank
    output logic       o_wr_en,
    output logic       o_rd_en,
    output addr_t      o_addr,
    output word_t      o_wdata
);
    // idle bus at time zero
    initial
    begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 16'h0000;
    end
    // one write, held until the taking edge, data scrambled after release
    task automatic write_word(input addr_t a, input word_t d);
        @(posedge i_clk);
        o_wr_en <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_wdata <= ~d;
    endtask
    // one read, answer picked up once the taking edge has settled
    task automatic read_word(input addr_t a, output word_t d, output logic v);
        @(posedge i_clk);
        o_rd_en <= 1'b1;
        o_addr  <= a;
        @(posedge i_clk);
        o_rd_en <= 1'b0;
        #1;
        d = i_rdata;
        v = i_rd_valid;
    endtask
endmodule

// [test/tb_rf_ctrl_regs.sv]
// self-checking bench of the receiver control bank
`timescale 1ns/100ps
`include "rf_ctrl_defines.svh"
module tb_rf_ctrl_regs
    import rf_ctrl_pkg::*;
;
    // ----------------------------------------------------------------
    // signals and tables
    // ----------------------------------------------------------------
    logic i_clk, i_sys_rst, wr_en, rd_en, rv, ext, pump, dv, rb, drv, cores, amp, loop, imode;
    addr_t addr;
    word_t wdata, rdata, got;
    word_t pwo, pmp, rfc, ocw, swc, trc, mxc, dtc, dic, dsd;
    logic [10:0] iv, fv, mv;
    logic [5:0] atten;
    logic [31:0] seed;
    int n_fail, comparisons;
    word_t exp_q [13];
    const addr_t AD[13] = '{`A_POWER_EN, `A_INT_DIV, `A_FRACTION, `A_MODULUS, `A_PUMP, `A_REFERENCE,
        `A_OSC_OUT, `A_INPUT_SW, `A_TRANSFORMER, `A_MIXER, `A_DETECTOR, `A_DITHER, `A_DITHER_SEED};
    const word_t RV[13] = '{16'h8b7f, 16'h0058, 16'h0250, 16'h0600, 16'h0c26, 16'h0003, 16'h000a,
        16'h0000, 16'h0000, 16'h08ef, 16'h0010, 16'h000e, 16'h0001};
    const word_t MK[13] = '{`M_POWER_EN, `M_INT_DIV, `M_FRACTION, `M_MODULUS, `M_PUMP, `M_REFERENCE,
        `M_OSC_OUT, `M_INPUT_SW, `M_TRANSFORMER, `M_MIXER, `M_DETECTOR, `M_DITHER, `M_DITHER_SEED};
    // clock of 10 ns
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // design and host
    rf_ctrl_regs dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rv), .o_ext_osc_mode(ext),
        .o_pump_on(pump), .o_divider_on(dv), .o_refbuf_on(rb), .o_osc_driver_on(drv),
        .o_oscillator_cores_on(cores), .o_intermediate_amp_on(amp), .o_synth_loop_on(loop),
        .o_power_word(pwo), .o_integer_mode(imode), .o_integer_value(iv), .o_fraction_value(fv),
        .o_modulus_value(mv), .o_pump_cfg(pmp), .o_reference_cfg(rfc), .o_osc_out_cfg(ocw),
        .o_input_switch_cfg(swc), .o_transformer_cfg(trc), .o_mixer_cfg(mxc), .o_detector_cfg(dtc),
        .o_dither_cfg(dic), .o_dither_seed(dsd), .o_atten_half_db(atten));
    reg_host host (.i_clk(i_clk), .i_rdata(rdata), .i_rd_valid(rv), .o_wr_en(wr_en),
        .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected gated enables: ext, pump, div, refbuf, driver, cores, amp, loop
    function automatic word_t gate_exp(input word_t pw, input logic [2:0] src);
        logic x;
        logic c;
        x = (src == 3'h3);
        c = (src < 3'h3);
        return {8'h00, x, pw[2] & ~x, pw[3] & ~x, pw[5] & ~x, pw[7] & ~x, pw[4] & c, pw[11],
            pw[2] & pw[3] & pw[5] & c};
    endfunction
    task automatic check(input word_t seen, input word_t want);
        comparisons++;
        if (seen !== want)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // read one word and compare data and valid flag together
    task automatic rd_check(input addr_t a, input word_t want);
        logic v;
        host.read_word(a, got, v);
        check(got, want);
        check({15'h0000, v}, 16'h0001);
    endtask
    task automatic all_check();
        word_t seen [13];
        for (int i = 0; i < 13; i++)
            rd_check(AD[i], exp_q[i]);
        // word outputs after the reads have settled
        seen = '{pwo, {4'h0, imode, iv}, {5'h00, fv}, {5'h00, mv}, pmp, rfc, ocw, swc, trc, mxc, dtc, dic, dsd};
        for (int i = 0; i < 13; i++)
            check(seen[i], exp_q[i]);
    endtask
    task automatic complete_run();
        if (n_fail == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog far beyond the expected run
    initial
    begin
        #400000;
        n_fail++;
        complete_run();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [2:0] src;
        word_t pw;
        n_fail = 0;
        comparisons = 0;
        seed = 32'h000185af;
        exp_q = RV;
        i_sys_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        all_check();
        rd_check(`A_SOFT_RESET, 16'h0000);
        rd_check(8'h05, 16'h0000);
        // random words into every register, reserved bits keep their value
        for (int i = 0; i < 13; i++)
        begin
            seed = lfsr_next(seed);
            host.write_word(AD[i], seed[15:0]);
            exp_q[i] = (seed[15:0] & MK[i]) | (RV[i] & ~MK[i]);
        end
        host.write_word(8'h05, 16'hffff);
        host.write_word(`A_SOFT_RESET, 16'hfffe);
        all_check();
        // soft reset restores every word
        host.write_word(`A_SOFT_RESET, 16'h0001);
        exp_q = RV;
        @(posedge i_clk);
        all_check();
        // gating of block enables, external mode first, then random
        for (int i = 0; i < 24; i++)
        begin
            seed = lfsr_next(seed);
            pw = (i == 0) ? 16'h8b53 : ((i == 1) ? 16'h8bbf : (seed[15:0] & `M_POWER_EN) | 16'h0040);
            src = (i < 2) ? 3'h3 : seed[18:16];
            host.write_word(`A_POWER_EN, pw);
            host.write_word(`A_OSC_OUT, {13'h0001, src});
            repeat (2) @(posedge i_clk);
            #1;
            check({8'h00, ext, pump, dv, rb, drv, cores, amp, loop}, gate_exp(pw, src));
        end
        // attenuation codes every third step from zero, up to and beyond the top step
        for (int c = 0; c < 32; c += 3)
        begin
            host.write_word(`A_INPUT_SW, {11'h000, c[4:0]});
            repeat (2) @(posedge i_clk);
            #1;
            check({10'h000, atten}, (c > 24) ? 16'h001e : 16'h0006 + 16'(c));
        end
        // divider mode bit, both codes
        for (int m = 0; m < 2; m++)
        begin
            host.write_word(`A_INT_DIV, {4'h0, m[0], 11'h123});
            repeat (2) @(posedge i_clk);
            #1;
            check({15'h0000, imode}, {15'h0000, m[0]});
        end
        complete_run();
    end
endmodule
